// file: rtl/hbp_port.sv
// Host bus port of a dual-channel UART: separate-strobe or direction-line style.
// Assumes the register file answers REG_RD_DATA in the same cycle as REG_RD_STB,
// and a pad ring builds the data and interrupt wires from the output enables.
`timescale 1ns/10ps
`include "hbp_defines.svh"

module hbp_port (
    input  wire logic              CLOCK,                    // System clock, 200 MHz
    input  wire logic              RESET_N,                  // Asynchronous reset, active low
    input  wire logic              BUS_STYLE,                // Bus style strap
    input  wire logic              READ_STROBE_N,            // Read strobe pin
    input  wire logic              WRITE_STROBE_N,           // Write strobe or direction pin
    input  wire logic              FIRST_CHANNEL_SELECT_N,   // First select or chip select
    input  wire logic              SECOND_CHANNEL_SELECT_N,  // Second select or channel bit
    input  wire hbp_pkg::hbp_addr_t REGISTER_ADDRESS,        // Register address pins
    input  wire hbp_pkg::hbp_data_t DATA_IN,                 // Data bus level at the pins
    output      hbp_pkg::hbp_data_t DATA_OUT,                // Data bus drive value
    output logic                   DATA_OE,                  // Data bus output enable
    output logic                   FIRST_CHANNEL_IRQ_O,      // Interrupt pin drive value
    output logic                   FIRST_CHANNEL_IRQ_OE,     // Interrupt pin output enable
    output logic                   FIRST_AUX_OUTPUT_N,       // First channel aux output
    input  wire hbp_pkg::hbp_chan_t IRQ_OUTPUT_ENABLE,       // Per channel irq output enable
    input  wire hbp_pkg::hbp_chan_t CHANNEL_IRQ_PEND,        // Per channel pending interrupt
    output logic                   REG_CHAN,                 // Channel of the access
    output      hbp_pkg::hbp_addr_t REG_ADDR,                // Register of the access
    output logic                   REG_RD_STB,               // Read request, one cycle
    input  wire hbp_pkg::hbp_data_t REG_RD_DATA,             // Read answer, same cycle
    output logic                   REG_WR_STB,               // Write strobe, one cycle
    output      hbp_pkg::hbp_data_t REG_WR_DATA              // Write byte
);
    import hbp_pkg::*;

    typedef struct packed {
        hbp_state_e state;     // Access sequencer
        logic       chan;      // Latched channel
        hbp_addr_t  addr;      // Latched register address
        logic       rd_stb;    // Read request, one cycle
        logic       wr_stb;    // Write strobe, one cycle
        hbp_data_t  wr_data;   // Write byte, tracked while strobe low
        hbp_data_t  rd_data;   // Byte driven to the host
        logic       data_oe;   // Data bus enable
        logic       irq_o;     // Interrupt pin value
        logic       irq_oe;    // Interrupt pin enable
        logic       aux_n;     // Aux output
    } hbp_core_s;

    hbp_core_s  st_q;          // Registered state
    hbp_core_s  st_d;          // Next state
    logic       sep;           // Separate-strobe style in force
    logic       sel_any;       // Some channel selected, separate style
    logic       rd_act;        // A read access is active
    logic       wr_act;        // A write access is active
    logic       chan_now;      // Channel the pins point at

    hbp_pin_if  pin_if ();     // Synchronised pins

    // All pins pass two flops before use
    hbp_sync u_sync (
        .CLOCK   (CLOCK),
        .RESET_N (RESET_N),
        .PINS    ({BUS_STYLE, READ_STROBE_N, WRITE_STROBE_N, FIRST_CHANNEL_SELECT_N,
                   SECOND_CHANNEL_SELECT_N, REGISTER_ADDRESS, DATA_IN}),
        .sy      (pin_if.sync_mp)
    );

    // Decode the access from the pins according to the style
    always_comb begin
        sep     = pin_if.pins.style;
        sel_any = !pin_if.pins.first_channel_select_n ||
                  !pin_if.pins.second_channel_select_n;
        if (sep) begin
            // First select wins if the host breaks the one-select rule
            chan_now = pin_if.pins.first_channel_select_n;
            rd_act   = sel_any && !pin_if.pins.rd_n;
            wr_act   = sel_any && !pin_if.pins.wr_n;
        end else begin
            // Read strobe ignored; write pin gives the direction
            chan_now = pin_if.pins.second_channel_select_n;
            rd_act   = !pin_if.pins.first_channel_select_n && pin_if.pins.wr_n;
            wr_act   = !pin_if.pins.first_channel_select_n && !pin_if.pins.wr_n;
        end
    end

    // Sequencer and output next values
    always_comb begin
        st_d        = st_q;
        st_d.rd_stb = 1'h0;
        st_d.wr_stb = 1'h0;
        case (st_q.state)
            HBP_IDLE: begin
                // Start only from an idle bus, so a new access needs a fresh edge
                if (rd_act) begin
                    st_d.chan   = chan_now;
                    st_d.addr   = pin_if.pins.addr;
                    st_d.rd_stb = 1'h1;
                    st_d.state  = HBP_RD_REQ;
                end else if (wr_act) begin
                    st_d.chan    = chan_now;
                    st_d.addr    = pin_if.pins.addr;
                    st_d.wr_data = pin_if.pins.data;
                    st_d.state   = HBP_WR_HOLD;
                end
            end
            HBP_RD_REQ: begin
                // Register answer arrives now; start driving
                st_d.rd_data = REG_RD_DATA;
                st_d.data_oe = 1'h1;
                st_d.state   = HBP_RD_HOLD;
            end
            HBP_RD_HOLD: begin
                // Hold the byte until the host lets the strobe rise
                if (!rd_act) begin
                    st_d.data_oe = 1'h0;
                    st_d.state   = HBP_IDLE;
                end
            end
            HBP_WR_HOLD: begin
                // Track address and data; commit on the rising edge
                if (wr_act) begin
                    st_d.addr    = pin_if.pins.addr;
                    st_d.wr_data = pin_if.pins.data;
                end else begin
                    st_d.wr_stb = 1'h1;
                    st_d.state  = HBP_IDLE;
                end
            end
            default: begin
                st_d.data_oe = 1'h0;
                st_d.state   = HBP_IDLE;
            end
        endcase
        // Interrupt pin follows style, enable and pending state
        if (sep) begin
            st_d.irq_o  = CHANNEL_IRQ_PEND[0];
            st_d.irq_oe = IRQ_OUTPUT_ENABLE[0];
        end else begin
            st_d.irq_o  = 1'h0;
            st_d.irq_oe = |CHANNEL_IRQ_PEND;
        end
        st_d.aux_n = !IRQ_OUTPUT_ENABLE[0];
    end

    // State register
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '{state: HBP_IDLE, chan: `HBP_CHAN_RST, addr: `HBP_ADDR_RST,
                      rd_stb: 1'h0, wr_stb: 1'h0, wr_data: `HBP_DATA_RST,
                      rd_data: `HBP_DATA_RST, data_oe: 1'h0, irq_o: 1'h0,
                      irq_oe: 1'h0, aux_n: 1'h1};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flops
    assign DATA_OUT             = st_q.rd_data;
    assign DATA_OE              = st_q.data_oe;
    assign FIRST_CHANNEL_IRQ_O  = st_q.irq_o;
    assign FIRST_CHANNEL_IRQ_OE = st_q.irq_oe;
    assign FIRST_AUX_OUTPUT_N   = st_q.aux_n;
    assign REG_CHAN             = st_q.chan;
    assign REG_ADDR             = st_q.addr;
    assign REG_RD_STB           = st_q.rd_stb;
    assign REG_WR_STB           = st_q.wr_stb;
    assign REG_WR_DATA          = st_q.wr_data;

    // Read request carries the sampled address and channel
    property p_rd_req;
        @(posedge CLOCK) disable iff (!RESET_N)
        (st_q.state == HBP_IDLE && rd_act) |=>
            REG_RD_STB && REG_ADDR == $past(pin_if.pins.addr) && REG_CHAN == $past(chan_now);
    endproperty
    a_rd_req: assert property (p_rd_req) else $error("read request not issued");

    // Answer byte appears on the bus one cycle after the request
    property p_rd_drive;
        @(posedge CLOCK) disable iff (!RESET_N)
        REG_RD_STB |=> DATA_OE && DATA_OUT == $past(REG_RD_DATA);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read byte not driven");

    // Bus released one cycle after the read ends, and still released the cycle after
    property p_rd_release;
        @(posedge CLOCK) disable iff (!RESET_N)
        (st_q.state == HBP_RD_HOLD && !rd_act) |=> !DATA_OE ##1 (DATA_OE == 1'h0);
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("bus held too long");

    // Write commits the last byte seen before the strobe rose
    property p_wr_commit;
        @(posedge CLOCK) disable iff (!RESET_N)
        (st_q.state == HBP_WR_HOLD && wr_act) ##1 !wr_act |=>
            REG_WR_STB && REG_WR_DATA == $past(pin_if.pins.data, 2);
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write byte lost");

    // Direction style: write pin high starts a read, low a write
    property p_dir_rw;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!sep && st_q.state == HBP_IDLE && !pin_if.pins.first_channel_select_n) |=>
            (REG_RD_STB == $past(pin_if.pins.wr_n)) && (st_q.state != HBP_IDLE);
    endproperty
    a_dir_rw: assert property (p_dir_rw) else $error("direction misdecoded");

    // No access starts without a select
    property p_no_sel;
        @(posedge CLOCK) disable iff (!RESET_N)
        (st_q.state == HBP_IDLE && pin_if.pins.first_channel_select_n &&
         (!sep || pin_if.pins.second_channel_select_n)) |=>
            st_q.state == HBP_IDLE;
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("access without select");

    // Separate style: each select routes to its own channel
    property p_sep_chan;
        @(posedge CLOCK) disable iff (!RESET_N)
        (sep && st_q.state == HBP_IDLE && rd_act) |=>
            REG_CHAN == $past(pin_if.pins.first_channel_select_n);
    endproperty
    a_sep_chan: assert property (p_sep_chan) else $error("wrong channel");

    // Direction style: channel bit routes the access
    property p_dir_chan;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!sep && st_q.state == HBP_IDLE && rd_act) |=>
            REG_CHAN == $past(pin_if.pins.second_channel_select_n);
    endproperty
    a_dir_chan: assert property (p_dir_chan) else $error("wrong channel bit");

    // Separate style: irq enable follows the control bit, aux is its inverse
    property p_irq_sep;
        @(posedge CLOCK) disable iff (!RESET_N)
        sep |=> FIRST_CHANNEL_IRQ_OE == $past(IRQ_OUTPUT_ENABLE[0]) &&
                FIRST_AUX_OUTPUT_N == !$past(IRQ_OUTPUT_ENABLE[0]);
    endproperty
    a_irq_sep: assert property (p_irq_sep) else $error("irq enable wrong");

    // Direction style: open drain, pulled low while either channel pends
    property p_irq_dir;
        @(posedge CLOCK) disable iff (!RESET_N)
        !sep |=> !FIRST_CHANNEL_IRQ_O && FIRST_CHANNEL_IRQ_OE == $past(|CHANNEL_IRQ_PEND);
    endproperty
    a_irq_dir: assert property (p_irq_dir) else $error("shared irq wrong");
endmodule

// file: rtl/hbp_defines.svh
// Constants of the dual-style host bus port: widths, reset values, pin idle levels.
// Included by the package and by the modules; the guard keeps a single copy.
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

`define HBP_DATA_W      8            // Data bus width
`define HBP_ADDR_W      3            // Register address lines
`define HBP_CHAN_N      2            // Number of UART channels
`define HBP_PINS_W      16           // Width of the gathered pin group
`define HBP_PINS_IDLE   16'hF800     // Style high, strobes and selects high, rest low
`define HBP_DATA_RST    8'h00        // Reset value of data holding flops
`define HBP_ADDR_RST    3'h0         // Reset value of the latched address
`define HBP_CHAN_RST    1'h0         // Reset value of the latched channel

`endif

// file: rtl/hbp_pkg.sv
// Types shared by the host bus port modules.
// Assumes hbp_defines.svh is found on the include path.
`include "hbp_defines.svh"

package hbp_pkg;

    typedef logic [`HBP_DATA_W-1:0] hbp_data_t;   // One bus byte
    typedef logic [`HBP_ADDR_W-1:0] hbp_addr_t;   // Register index in a channel
    typedef logic [`HBP_CHAN_N-1:0] hbp_chan_t;   // One bit per channel

    // Access sequencer states, Gray along idle, request, hold
    typedef enum logic [1:0] {
        HBP_IDLE    = 2'h0,
        HBP_RD_REQ  = 2'h1,
        HBP_RD_HOLD = 2'h3,
        HBP_WR_HOLD = 2'h2
    } hbp_state_e;

    // Host pins gathered in one group, MSB first
    typedef struct packed {
        logic      style;      // Bus style strap, high selects separate strobes
        logic      rd_n;       // Read strobe
        logic      wr_n;       // Write strobe or direction line
        logic      first_channel_select_n;   // First channel select or chip select
        logic      second_channel_select_n;  // Second channel select or channel bit
        hbp_addr_t addr;       // Register address
        hbp_data_t data;       // Data bus as seen at the pins
    } hbp_pins_s;

endpackage

// file: rtl/hbp_pin_if.sv
// Carrier of the synchronised host pin group between synchroniser and core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface hbp_pin_if;
    hbp_pkg::hbp_pins_s pins;   // Pin levels after two flops

    modport sync_mp (output pins);
    modport core_mp (input  pins);
endinterface

// file: rtl/hbp_sync.sv
// Two-flop synchroniser for the asynchronous host pin group.
// Assumes pins change freely with respect to CLOCK; bus skew settles within strobe setup.
`timescale 1ns/10ps
`include "hbp_defines.svh"

module hbp_sync (
    input  wire logic               CLOCK,    // System clock
    input  wire logic               RESET_N,  // Asynchronous reset, active low
    input  wire hbp_pkg::hbp_pins_s PINS,     // Raw pin levels
    hbp_pin_if.sync_mp              sy        // Synchronised pin levels
);
    import hbp_pkg::*;

    typedef struct packed {
        hbp_pins_s meta;   // First stage, read only by second stage
        hbp_pins_s sync;   // Second stage, safe to use
    } hbp_sync_s;

    hbp_sync_s  st_q;      // Registered state
    hbp_sync_s  st_d;      // Next state

    // Shift pins through two stages
    always_comb begin
        st_d      = st_q;
        st_d.meta = PINS;
        st_d.sync = st_q.meta;
    end

    // State register, pins idle under reset
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= {`HBP_PINS_IDLE, `HBP_PINS_IDLE};
        end else begin
            st_q <= st_d;
        end
    end

    assign sy.pins = st_q.sync;
endmodule

// file: tb/hbp_host_model.sv
// Host processor model driving the asynchronous parallel bus of the port.
// Assumes the bench calls set_style and access, one access at a time.
`timescale 1ns/10ps

module hbp_host_model (
    input  wire logic               clock,                    // Pacing clock
    input  wire hbp_pkg::hbp_data_t data_out,                 // Device drive value
    input  wire logic               data_oe,                  // Device drive enable
    output logic                    bus_style,                // Bus style strap
    output logic                    read_strobe_n,            // Read strobe
    output logic                    write_strobe_n,           // Write strobe or direction
    output logic                    first_channel_select_n,   // First select or chip select
    output logic                    second_channel_select_n,  // Second select or channel bit
    output hbp_pkg::hbp_addr_t      register_address,         // Register address
    output hbp_pkg::hbp_data_t      data_in                   // Resolved bus level
);
    import hbp_pkg::*;
    localparam int HOLD_CYC = 8;  // Clocks an access stays active
    localparam int IDLE_CYC = 6;  // Clocks after an access, covers end latency
    logic      drive;    // Host drives the bus
    hbp_data_t drv_val;  // Byte the host drives
    hbp_data_t last_q;   // Previous bus level

    // A released bus shows a changing pattern, never the last value
    assign data_in = data_oe ? data_out : (drive ? drv_val : ~last_q);

    // Track the bus level for the floating pattern
    always @(posedge clock) begin
        last_q <= data_in;
    end

    // Quiet host at time zero
    initial begin
        bus_style = 1'b1;
        register_address = 3'h0;
        drv_val = 8'h00;
        last_q = 8'h00;
        idle();
    end

    // All strobes and selects inactive, bus released
    task automatic idle();
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        first_channel_select_n = 1'b1;
        second_channel_select_n = 1'b1;
        drive = 1'b0;
    endtask

    // Change the strap and let it settle
    task automatic set_style(input logic sep);
        @(posedge clock);
        #1;
        bus_style = sep;
        repeat (IDLE_CYC) @(posedge clock);
    endtask

    // One byte access; sel_on low leaves the device unselected
    task automatic access(input logic sep, input logic rd, input logic chan, input hbp_addr_t a,
                          input hbp_data_t wdat, input logic sel_on, output hbp_data_t rdat);
        @(posedge clock);
        #1;
        register_address = a;
        drive = !rd;
        drv_val = wdat;
        if (sep) begin
            first_channel_select_n = !(sel_on && !chan);
            second_channel_select_n = !(sel_on && chan);
        end else begin
            write_strobe_n = rd;
            second_channel_select_n = chan;
        end
        @(posedge clock);
        #1;
        if (!sep) begin
            first_channel_select_n = !sel_on;
        end else if (rd) begin
            read_strobe_n = 1'b0;
        end else begin
            write_strobe_n = 1'b0;
        end
        repeat (HOLD_CYC) @(posedge clock);
        rdat = data_in;
        #1;
        read_strobe_n = 1'b1;
        if (sep) begin
            write_strobe_n = 1'b1;
        end else begin
            first_channel_select_n = 1'b1;
        end
        // Address and data held one more cycle past the strobe rise
        @(posedge clock);
        #1;
        idle();
        repeat (IDLE_CYC) @(posedge clock);
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the host bus port: both bus styles, register traffic, irq pins.
// Assumes the host model and a behavioural register file stand around the port.
`timescale 1ns/10ps

module tb_top;
    import hbp_pkg::*;
    logic      CLOCK, RESET_N, BUS_STYLE, READ_STROBE_N, WRITE_STROBE_N;  // Clock and pins
    logic      FIRST_CHANNEL_SELECT_N, SECOND_CHANNEL_SELECT_N;          // Select pins
    logic      DATA_OE, FIRST_CHANNEL_IRQ_O, FIRST_CHANNEL_IRQ_OE;       // Pin drives
    logic      FIRST_AUX_OUTPUT_N, REG_CHAN, REG_RD_STB, REG_WR_STB;     // Aux, register side
    hbp_addr_t REGISTER_ADDRESS, REG_ADDR;                               // Addresses
    hbp_data_t DATA_IN, DATA_OUT, REG_RD_DATA, REG_WR_DATA;              // Bytes
    hbp_chan_t IRQ_OUTPUT_ENABLE, CHANNEL_IRQ_PEND;                      // Irq sources
    hbp_data_t regs_q [16];                                              // Register file
    hbp_data_t exp_mem [16];                                             // Expected contents
    int        fails, comparisons, rd_cnt, wr_cnt;                       // Counters
    integer    seed;                                                     // Random seed

    // 200 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    // Register file: reads answer at once, writes land on the strobe
    assign REG_RD_DATA = regs_q[{REG_CHAN, REG_ADDR}];
    always @(posedge CLOCK) begin
        if (REG_WR_STB === 1'b1) begin
            regs_q[{REG_CHAN, REG_ADDR}] <= REG_WR_DATA;
        end
        rd_cnt <= rd_cnt + int'(REG_RD_STB === 1'b1);
        wr_cnt <= wr_cnt + int'(REG_WR_STB === 1'b1);
    end

    hbp_port i_dut (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .BUS_STYLE(BUS_STYLE),
        .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
        .FIRST_CHANNEL_SELECT_N(FIRST_CHANNEL_SELECT_N),
        .SECOND_CHANNEL_SELECT_N(SECOND_CHANNEL_SELECT_N), .REGISTER_ADDRESS(REGISTER_ADDRESS),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
        .FIRST_CHANNEL_IRQ_O(FIRST_CHANNEL_IRQ_O), .FIRST_CHANNEL_IRQ_OE(FIRST_CHANNEL_IRQ_OE),
        .FIRST_AUX_OUTPUT_N(FIRST_AUX_OUTPUT_N), .IRQ_OUTPUT_ENABLE(IRQ_OUTPUT_ENABLE),
        .CHANNEL_IRQ_PEND(CHANNEL_IRQ_PEND), .REG_CHAN(REG_CHAN), .REG_ADDR(REG_ADDR),
        .REG_RD_STB(REG_RD_STB), .REG_RD_DATA(REG_RD_DATA), .REG_WR_STB(REG_WR_STB),
        .REG_WR_DATA(REG_WR_DATA)
    );

    hbp_host_model i_host (
        .clock(CLOCK), .data_out(DATA_OUT), .data_oe(DATA_OE), .bus_style(BUS_STYLE),
        .read_strobe_n(READ_STROBE_N), .write_strobe_n(WRITE_STROBE_N),
        .first_channel_select_n(FIRST_CHANNEL_SELECT_N),
        .second_channel_select_n(SECOND_CHANNEL_SELECT_N),
        .register_address(REGISTER_ADDRESS), .data_in(DATA_IN)
    );

    // Irq pin enable: own enable bit, or any pending when shared
    function automatic logic exp_irq_oe(input logic sep, input hbp_chan_t en, input hbp_chan_t p);
        return sep ? en[0] : |p;
    endfunction

    // Irq pin value: pending level, or the open-drain low
    function automatic logic exp_irq_o(input logic sep, input hbp_chan_t p);
        return sep ? p[0] : 1'b0;
    endfunction

    // Byte compare
    task automatic chk_data(input hbp_data_t got, input hbp_data_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Flag compare
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One access, then count register strobes and check the bus is released
    task automatic run_acc(input logic sep, input logic rd, input logic [3:0] loc,
                           input hbp_data_t wdat, input logic sel_on, output hbp_data_t rdat);
        int r0;
        int w0;
        r0 = rd_cnt;
        w0 = wr_cnt;
        i_host.access(sep, rd, loc[3], loc[2:0], wdat, sel_on, rdat);
        chk_data(8'(rd_cnt - r0), 8'(rd && sel_on));
        chk_data(8'(wr_cnt - w0), 8'(!rd && sel_on));
        chk_flag(DATA_OE, 1'b0);
    endtask

    // Fill all sixteen registers, try unselected traffic, read back in reverse
    task automatic mem_test(input logic sep);
        hbp_data_t rdat;
        for (int i = 0; i < 16; i++) begin
            exp_mem[i] = (i == 0) ? 8'h00 : (i == 15) ? 8'hFF : 8'($random(seed));
            run_acc(sep, 1'b0, 4'(i), exp_mem[i], 1'b1, rdat);
        end
        run_acc(sep, 1'b0, 4'h5, ~exp_mem[5], 1'b0, rdat);
        run_acc(sep, 1'b1, 4'hD, 8'h00, 1'b0, rdat);
        for (int i = 15; i >= 0; i--) begin
            run_acc(sep, 1'b1, 4'(i), 8'h00, 1'b1, rdat);
            chk_data(rdat, exp_mem[i]);
        end
        $display("test registers style %0d done", sep);
    endtask

    // Every enable and pending combination, one cycle latency
    task automatic irq_test(input logic sep);
        hbp_chan_t en;
        hbp_chan_t p;
        for (int i = 0; i < 16; i++) begin
            en = 2'(i);
            p = 2'(i >> 2);
            @(posedge CLOCK);
            #1;
            IRQ_OUTPUT_ENABLE = en;
            CHANNEL_IRQ_PEND = p;
            @(posedge CLOCK);
            #1;
            chk_flag(FIRST_CHANNEL_IRQ_OE, exp_irq_oe(sep, en, p));
            chk_flag(FIRST_CHANNEL_IRQ_O, exp_irq_o(sep, p));
            chk_flag(FIRST_AUX_OUTPUT_N, !en[0]);
        end
        $display("test irq style %0d done", sep);
    endtask

    // Counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #100000;
        fails++;
        summarize();
    end

    // Main sequence
    initial begin
        seed = 37719;
        fails = 0;
        comparisons = 0;
        rd_cnt = 0;
        wr_cnt = 0;
        RESET_N = 1'b0;
        IRQ_OUTPUT_ENABLE = 2'h0;
        CHANNEL_IRQ_PEND = 2'h0;
        for (int i = 0; i < 16; i++) begin
            regs_q[i] = 8'h00;
        end
        repeat (2) @(posedge CLOCK);
        #1;
        chk_flag(DATA_OE, 1'b0);
        chk_flag(FIRST_AUX_OUTPUT_N, 1'b1);
        chk_flag(REG_WR_STB, 1'b0);
        RESET_N = 1'b1;
        repeat (3) @(posedge CLOCK);
        $display("test reset done");
        mem_test(1'b1);
        irq_test(1'b1);
        i_host.set_style(1'b0);
        mem_test(1'b0);
        irq_test(1'b0);
        summarize();
    end
endmodule
